// [pkg/pat_mask_pkg.sv]
// Shared types and constants for the pattern transparency and byte-mask datapath.
// Assumes the engine supplies one pixel per cycle with a valid strobe.
package pat_mask_pkg;
	localparam int PIX_W      = 32;
	localparam int BYTES      = 4;
	localparam int OPC_W      = 8;
	localparam int ALPHA_BYTE = 3;
	localparam int MSK_ALPHA  = 1;
	localparam int MSK_RGB    = 0;
	localparam logic [1:0] MSK_RST   = 2'h0;
	localparam logic [1:0] DEPTH_32  = 2'h3;
	localparam logic [1:0] DEPTH_RST = 2'h0;
	// Opcode bits that flag a monochrome or colour pattern operand
	localparam logic [OPC_W-1:0] OPC_MONO_PAT  = 8'h01;
	localparam logic [OPC_W-1:0] OPC_COLOR_PAT = 8'h02;
	localparam logic [PIX_W-1:0] PIX_RST  = 32'h00000000;
	localparam logic [BYTES-1:0] BEN_NONE = 4'h0;
	localparam logic [BYTES-1:0] BEN_ALL  = 4'hF;

	typedef struct packed {
		logic             valid;
		logic             pat_bit;
		logic [PIX_W-1:0] rop_result;
	} pixel_in_t;

	typedef struct packed {
		logic             valid;
		logic [PIX_W-1:0] data;
		logic [BYTES-1:0] byte_en;
	} pixel_out_t;
endpackage

// [verilog/pat_opcode_decode.sv]
// Opcode decoder: classifies the pattern operand of the current command.
// Assumes the opcode is stable while cmd_start is high.
`timescale 1ns/100ps
module pat_opcode_decode
(
	// Clock and reset
	input  wire logic                            sys_clk,
	input  wire logic                            sys_rst,
	// Command
	input  wire logic                            cmd_start,
	input  wire logic [pat_mask_pkg::OPC_W-1:0]  opcode,
	// Decoded pattern kind
	output logic                                 mono_pat_ff,
	output logic                                 color_pat_ff
);
	// Latched per command, so a mid-command opcode change cannot flip the kind
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			mono_pat_ff  <= 1'b0;
			color_pat_ff <= 1'b0;
		end
		else if (cmd_start)
		begin
			mono_pat_ff  <= |(opcode & pat_mask_pkg::OPC_MONO_PAT);
			color_pat_ff <= |(opcode & pat_mask_pkg::OPC_COLOR_PAT);
		end
	end
endmodule

// [verilog/pattern_transparency_write_mask.sv]
// Destination write gating: pattern transparency and 32bpp byte mask.
// Assumes the raster-op unit computes rop_result from the pattern operand
// we return (pat_operand) combinationally within the same cycle.
`timescale 1ns/100ps
module pattern_transparency_write_mask
#(
	parameter int PIX_W = pat_mask_pkg::PIX_W
)
(
	// Clock and reset
	input  wire logic                              sys_clk,
	input  wire logic                              sys_rst,
	// Command and configuration
	input  wire logic                              cmd_start,
	input  wire logic [pat_mask_pkg::OPC_W-1:0]    opcode,
	input  wire logic                              pat_transparent,
	input  wire logic [1:0]                        byte_mask,
	input  wire logic [1:0]                        color_depth,
	// Colours and pattern operand
	input  wire logic [PIX_W-1:0]                  bg_color,
	input  wire logic [PIX_W-1:0]                  fg_color,
	input  wire logic [PIX_W-1:0]                  color_pat_pixel,
	output logic      [PIX_W-1:0]                  pat_operand,
	// Pixel stream
	input  wire pat_mask_pkg::pixel_in_t           pix_in,
	output pat_mask_pkg::pixel_out_t               pix_out_ff,
	// Status
	output logic                                   mono_pat_ff,
	output logic                                   color_pat_ff
);
	// Lane and struct widths are fixed by the package, so refuse any other width
	generate
		if (PIX_W != pat_mask_pkg::PIX_W)
		begin : g_bad_width
			$error("pixel width must be 32");
		end
	endgenerate

	logic [pat_mask_pkg::BYTES-1:0] nxt_ben;
	logic [pat_mask_pkg::BYTES-1:0] depth_ben;
	logic                           pix_write;

	pat_opcode_decode u_dec
	(
		.sys_clk      (sys_clk),
		.sys_rst      (sys_rst),
		.cmd_start    (cmd_start),
		.opcode       (opcode),
		.mono_pat_ff  (mono_pat_ff),
		.color_pat_ff (color_pat_ff)
	);

	// Operand fed to the raster op; colour patterns pass through untouched
	always_comb
	begin
		if (mono_pat_ff)
			pat_operand = pix_in.pat_bit ? fg_color : bg_color;
		else
			pat_operand = color_pat_pixel;
	end

	// Pixel-level write decision
	always_comb
	begin
		if (mono_pat_ff && !pix_in.pat_bit && pat_transparent)
			pix_write = 1'b0;
		else
			pix_write = 1'b1;
	end

	// Byte mask applies only on 32bpp surfaces; at other depths depth_ben enables all lanes
	genvar b;
	generate
		for (b = 0; b < pat_mask_pkg::BYTES; b++)
		begin : g_lane
			if (b == pat_mask_pkg::ALPHA_BYTE)
			begin : g_alpha
				assign depth_ben[b] = (color_depth != pat_mask_pkg::DEPTH_32) ||
					byte_mask[pat_mask_pkg::MSK_ALPHA];
			end
			else
			begin : g_rgb
				assign depth_ben[b] = (color_depth != pat_mask_pkg::DEPTH_32) ||
					byte_mask[pat_mask_pkg::MSK_RGB];
			end
		end
	endgenerate

	assign nxt_ben = pix_write ? depth_ben : pat_mask_pkg::BEN_NONE;

	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			pix_out_ff.valid   <= 1'b0;
			pix_out_ff.data    <= pat_mask_pkg::PIX_RST;
			pix_out_ff.byte_en <= pat_mask_pkg::BEN_NONE;
		end
		else
		begin
			pix_out_ff.valid   <= pix_in.valid;
			pix_out_ff.data    <= pix_in.rop_result;
			pix_out_ff.byte_en <= pix_in.valid ? nxt_ben : pat_mask_pkg::BEN_NONE;
		end
	end

	a_transp_block: assert property (@(posedge sys_clk) disable iff (sys_rst)
		pix_in.valid && mono_pat_ff && !pix_in.pat_bit && pat_transparent
		|=> pix_out_ff.byte_en == pat_mask_pkg::BEN_NONE)
		else $error("transparent zero pattern bit wrote bytes");

	a_one_writes: assert property (@(posedge sys_clk) disable iff (sys_rst)
		pix_in.valid && mono_pat_ff && pix_in.pat_bit && color_depth != pat_mask_pkg::DEPTH_32
		|=> pix_out_ff.byte_en == pat_mask_pkg::BEN_ALL)
		else $error("one pattern bit did not write");

	a_default_bg: assert property (@(posedge sys_clk) disable iff (sys_rst)
		mono_pat_ff && !pix_in.pat_bit |-> pat_operand == bg_color)
		else $error("background colour not used for zero bit");

	a_default_wr: assert property (@(posedge sys_clk) disable iff (sys_rst)
		pix_in.valid && mono_pat_ff && !pat_transparent && color_depth != pat_mask_pkg::DEPTH_32
		|=> pix_out_ff.byte_en == pat_mask_pkg::BEN_ALL)
		else $error("default mode suppressed a write");

	a_color_ignore: assert property (@(posedge sys_clk) disable iff (sys_rst)
		pix_in.valid && !mono_pat_ff && color_depth != pat_mask_pkg::DEPTH_32
		|=> pix_out_ff.byte_en == pat_mask_pkg::BEN_ALL)
		else $error("transparency applied to colour pattern");

	a_color_operand: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!mono_pat_ff |-> pat_operand == color_pat_pixel)
		else $error("colour pattern operand altered");

	a_opcode_kind: assert property (@(posedge sys_clk) disable iff (sys_rst)
		cmd_start |=> mono_pat_ff == |($past(opcode) & pat_mask_pkg::OPC_MONO_PAT))
		else $error("pattern kind not from opcode");

	// Expected lanes rebuilt from the inputs, not from the internal write decision
	a_mask_alpha: assert property (@(posedge sys_clk) disable iff (sys_rst)
		pix_in.valid && color_depth == pat_mask_pkg::DEPTH_32
		|=> pix_out_ff.byte_en[pat_mask_pkg::ALPHA_BYTE] ==
			($past(byte_mask[pat_mask_pkg::MSK_ALPHA]) &&
			!($past(mono_pat_ff) && !$past(pix_in.pat_bit) && $past(pat_transparent))))
		else $error("alpha byte mask wrong");

	a_mask_rgb: assert property (@(posedge sys_clk) disable iff (sys_rst)
		pix_in.valid && color_depth == pat_mask_pkg::DEPTH_32
		|=> pix_out_ff.byte_en[pat_mask_pkg::ALPHA_BYTE-1:0] ==
			{3{$past(byte_mask[pat_mask_pkg::MSK_RGB]) &&
			!($past(mono_pat_ff) && !$past(pix_in.pat_bit) && $past(pat_transparent))}})
		else $error("colour byte mask wrong");

	a_fg_operand: assert property (@(posedge sys_clk) disable iff (sys_rst)
		mono_pat_ff && pix_in.pat_bit |-> pat_operand == fg_color)
		else $error("foreground colour not used for one bit");

	a_kind_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!cmd_start |=> $stable(mono_pat_ff) && $stable(color_pat_ff))
		else $error("pattern kind changed without a command");

	a_colour_kind: assert property (@(posedge sys_clk) disable iff (sys_rst)
		cmd_start |=> color_pat_ff == |($past(opcode) & pat_mask_pkg::OPC_COLOR_PAT))
		else $error("colour kind not from opcode");

	a_valid_pass: assert property (@(posedge sys_clk) disable iff (sys_rst)
		pix_in.valid |=> pix_out_ff.valid && pix_out_ff.data == $past(pix_in.rop_result))
		else $error("pixel not passed through");

	// A dropped strobe must never leave lanes enabled from the previous pixel
	a_idle_quiet: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!pix_in.valid |=> !pix_out_ff.valid && pix_out_ff.byte_en == pat_mask_pkg::BEN_NONE)
		else $error("lanes enabled without a pixel");

	a_transp_valid: assert property (@(posedge sys_clk) disable iff (sys_rst)
		pix_in.valid && mono_pat_ff && !pix_in.pat_bit && pat_transparent
		|=> pix_out_ff.valid)
		else $error("transparent pixel lost its strobe");

	a_depth_all: assert property (@(posedge sys_clk) disable iff (sys_rst)
		pix_in.valid && color_depth != pat_mask_pkg::DEPTH_32 && !pat_transparent
		|=> pix_out_ff.byte_en == pat_mask_pkg::BEN_ALL)
		else $error("byte mask applied below 32bpp");

	c_transp: cover property (@(posedge sys_clk) disable iff (sys_rst)
		pix_in.valid && mono_pat_ff && !pix_in.pat_bit && pat_transparent);
	c_default: cover property (@(posedge sys_clk) disable iff (sys_rst)
		pix_in.valid && mono_pat_ff && !pix_in.pat_bit && !pat_transparent);
	c_color: cover property (@(posedge sys_clk) disable iff (sys_rst)
		pix_in.valid && color_pat_ff);
	c_alpha_only: cover property (@(posedge sys_clk) disable iff (sys_rst)
		pix_in.valid && color_depth == pat_mask_pkg::DEPTH_32 && byte_mask == 2'h2);
	c_mono_low_depth: cover property (@(posedge sys_clk) disable iff (sys_rst)
		pix_in.valid && mono_pat_ff && color_depth != pat_mask_pkg::DEPTH_32);
endmodule

// [bench/pattern_transparency_write_mask_tb.sv]
// Self-checking bench for the pattern transparency and byte-mask datapath.
// Assumes the hand-over timing: one command, then one pixel a cycle later.
`timescale 1ns/100ps
module pattern_transparency_write_mask_tb;
	typedef struct packed {
		logic [7:0] opc;
		logic       tr;
		logic       pb;
		logic [1:0] msk;
		logic [1:0] dep;
		logic [3:0] ben;
	} row_t;
	localparam logic [7:0]  mo  = pat_mask_pkg::OPC_MONO_PAT;
	localparam logic [7:0]  co  = pat_mask_pkg::OPC_COLOR_PAT;
	localparam logic [31:0] bg  = 32'h11223344;
	localparam logic [31:0] fg  = 32'hA5A5A5A5;
	localparam logic [31:0] cp  = 32'h0F0F0F0F;
	localparam logic [31:0] rop = 32'hC0DE0000;
	logic                     sys_clk         = 1'h0;
	logic                     sys_rst         = 1'h1;
	logic                     cmd_start       = 1'h0;
	logic                     pat_transparent = 1'h0;
	logic [7:0]               opcode          = 8'h00;
	logic [1:0]               byte_mask       = 2'h0;
	logic [1:0]               color_depth     = 2'h0;
	logic [31:0]              pat_operand;
	logic                     mono_pat_ff;
	logic                     color_pat_ff;
	pat_mask_pkg::pixel_in_t  pix_in          = '0;
	pat_mask_pkg::pixel_out_t pix_out_ff;
	int                       n_errors        = 0;
	int                       n_checks        = 0;
	row_t                     r;
	row_t rows [0:11] = '{
		'{mo, 1'h0, 1'h0, 2'h3, 2'h3, 4'hF},
		'{mo, 1'h1, 1'h0, 2'h3, 2'h3, 4'h0},
		'{mo, 1'h1, 1'h1, 2'h3, 2'h3, 4'hF},
		'{co, 1'h1, 1'h0, 2'h3, 2'h3, 4'hF},
		'{mo, 1'h0, 1'h1, 2'h2, 2'h3, 4'h8},
		'{mo, 1'h1, 1'h1, 2'h1, 2'h3, 4'h7},
		'{mo, 1'h0, 1'h0, 2'h0, 2'h3, 4'h0},
		'{co, 1'h0, 1'h1, 2'h0, 2'h2, 4'hF},
		'{co, 1'h1, 1'h0, 2'h2, 2'h3, 4'h8},
		'{mo, 1'h0, 1'h0, 2'h0, 2'h0, 4'hF},
		'{mo, 1'h1, 1'h1, 2'h0, 2'h1, 4'hF},
		'{mo, 1'h1, 1'h0, 2'h3, 2'h2, 4'h0}
	};

	pattern_transparency_write_mask dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.cmd_start(cmd_start), .opcode(opcode), .pat_transparent(pat_transparent),
		.byte_mask(byte_mask), .color_depth(color_depth), .bg_color(bg), .fg_color(fg),
		.color_pat_pixel(cp), .pat_operand(pat_operand), .pix_in(pix_in),
		.pix_out_ff(pix_out_ff), .mono_pat_ff(mono_pat_ff), .color_pat_ff(color_pat_ff));

	initial forever #25 sys_clk = ~sys_clk;

	task automatic chk_w(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic chk_b(input string nm, input logic [3:0] exp, input logic [3:0] got);
		n_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic complete_run;
		$display("Checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Every registered output cleared while reset is held
	task automatic rst_chk;
		chk_w("rst_data", 32'h0, pix_out_ff.data);
		chk_b("rst_ben", 4'h0, pix_out_ff.byte_en);
		chk_b("rst_flags", 4'h0, {1'h0, pix_out_ff.valid, color_pat_ff, mono_pat_ff});
	endtask

	// Fixed-length sequence; this only guards against a stuck run
	initial
	begin
		repeat (500) @(posedge sys_clk);
		n_errors++;
		$display("Error timeout reached");
		complete_run;
	end

	initial
	begin
		repeat (4) @(posedge sys_clk);
		@(negedge sys_clk);
		rst_chk;
		@(posedge sys_clk);
		sys_rst <= 1'h0;
		for (int i = 0; i < 12; i++)
		begin
			r = rows[i];
			@(posedge sys_clk);
			cmd_start       <= 1'h1;
			opcode          <= r.opc;
			pat_transparent <= r.tr;
			byte_mask       <= r.msk;
			color_depth     <= r.dep;
			@(posedge sys_clk);
			cmd_start <= 1'h0;
			pix_in    <= '{1'h1, r.pb, rop ^ 32'(i)};
			@(negedge sys_clk);
			chk_b("kind", {2'h0, r.opc[1:0]}, {2'h0, color_pat_ff, mono_pat_ff});
			chk_w("pat_operand", r.opc[0] ? (r.pb ? fg : bg) : cp, pat_operand);
			@(posedge sys_clk);
			pix_in.valid <= 1'h0;
			@(negedge sys_clk);
			chk_w("data", rop ^ 32'(i), pix_out_ff.data);
			chk_b("byte_en", r.ben, pix_out_ff.byte_en);
			chk_b("valid", 4'h1, {3'h0, pix_out_ff.valid});
			$display("Row %0d done", i);
		end
		// Idle cycle: no pixel, no lanes
		@(negedge sys_clk);
		chk_b("idle_ben", 4'h0, pix_out_ff.byte_en);
		chk_b("idle_valid", 4'h0, {3'h0, pix_out_ff.valid});
		$display("Idle test done");
		// Reset landing on a live pixel
		@(posedge sys_clk);
		pix_in  <= '{1'h1, 1'h1, rop};
		sys_rst <= 1'h1;
		@(negedge sys_clk);
		rst_chk;
		$display("Mid-run reset test done");
		complete_run;
	end
endmodule
